/* verilog/mifd_cfg.svh */
// Register offsets, field positions and reset values for the machine
// input function decoder.
// Assumes a byte-addressed plain register port with 32-bit data words.
`ifndef MIFD_CFG_SVH
`define MIFD_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CONFIG 8'h00
`define REG_UP_COUNT 8'h04
`define REG_DOWN_COUNT 8'h08
`define REG_PATTERN 8'h0C
`define REG_SPEED 8'h10
`define REG_STATUS 8'h14

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define CFG_EXT_PATTERN_EN 0
`define CFG_BASE_LO 1
`define CFG_BASE_HI 2
`define CFG_JIG_FUNC_EN 3
`define CFG_JIG_SENSOR_EN 4
`define CFG_COMM_SETTING 5
`define CFG_RESET 6'h00

// ----------------------------------------------------------------------
// Pattern bases selected by the base offset field
// ----------------------------------------------------------------------
`define PATTERN_BASE_0 13'h3E8
`define PATTERN_BASE_1 13'h7D0
`define PATTERN_BASE_2 13'hBB8
`define PATTERN_BASE_3 13'hFA0

// ----------------------------------------------------------------------
// Speed dial limits and reset values
// ----------------------------------------------------------------------
`define SPEED_MAX 4'h9
`define SPEED_MIN 4'h0
`define SPEED_RESET 4'h0
`define COUNT_RESET 16'h0000

// ----------------------------------------------------------------------
// Bit positions of the edge-detected event vector
// ----------------------------------------------------------------------
`define EV_UP_INC 0
`define EV_UP_DEC 1
`define EV_DN_INC 2
`define EV_DN_DEC 3
`define EV_SPD_UP 4
`define EV_SPD_DN 5
`define EV_BARCODE 6
`define EV_THICK_CLR 7
`define EV_STITCH_CLR 8
`define EV_STITCH_B_CLR 9
`define EV_SEL_LO 10
`define EV_SEL_HI 19

// ----------------------------------------------------------------------
// Detection result bit positions
// ----------------------------------------------------------------------
`define RES_THICK_OK 0
`define RES_THICK_NG_POS 1
`define RES_THICK_NG_NEG 2
`define RES_STITCH_OK 3
`define RES_STITCH_NG 4
`define RES_STITCH_B_OK 5
`define RES_STITCH_B_NG 6

`endif

/* verilog/mifd_pkg.sv */
// Types shared by the machine input function decoder.
// Assumes the constants of mifd_cfg.svh for widths of fields.
package mifd_pkg;

  // ----------------------------------------------------------------------
  // Field types
  // ----------------------------------------------------------------------
  typedef logic [15:0] count_t;
  typedef logic [12:0] pattern_num_t;
  typedef logic [3:0] speed_t;
  typedef logic [19:0] event_vec_t;
  typedef logic [6:0] result_t;
  typedef logic [5:0] config_t;

  // ----------------------------------------------------------------------
  // Whole state of the decoder
  // ----------------------------------------------------------------------
  typedef struct packed {
    event_vec_t evt_prev;
    config_t cfg;
    count_t up_count;
    count_t down_count;
    speed_t speed;
    pattern_num_t pattern_num;
    logic pattern_valid;
    logic head_tilt_msg;
    logic [9:0] key_out;
    logic [3:0] icon_out;
    logic clamp;
    logic barcode_req;
    result_t results;
    logic [31:0] rdata;
  } state_t;

endpackage : mifd_pkg

/* verilog/machine_input_function_decoder.sv */
// Decoder for configurable external input functions of a sewing machine
// controller: counter steps, key and icon lockout, pattern number select,
// head tilt message, speed dial, cassette jig clamp, barcode read enable
// and clearing of detection result outputs.
// Assumes all inputs are synchronous to core_clk_i and that software uses
// the plain register port with read data one cycle after the strobe.
//
// Overview of operation
// R1: Down counter is cleared while the down-count clear input is active.
// R2: Up counter adds one on each up-increment activation.
// R3: Up counter subtracts one on each up-decrement activation.
// R4: Down counter adds one on each down-increment activation.
// R5: Down counter subtracts one on each down-decrement activation.
// R6: Each of ten panel keys is ignored while its lockout input is active.
// R7: Each of four panel icons is ignored while its lockout is active.
// R8: Pattern number is base 1000 plus weights 1,2,4,8,16,32 of inputs.
// R9: With default base the selected pattern stays in 1000 to 1063.
// R10: Pattern weight inputs act only while external select is enabled.
// R11: Base offset setting picks base 1000, 2000, 3000 or 4000.
// R12: Head tilt input raises the head tilt message while active.
// R13: Ten speed select inputs set the speed dial to 0 to 9.
// R14: Each speed-up activation raises the speed dial by one.
// R15: Each speed-down activation lowers the speed dial by one.
// R16: Both jig sensors active turn on clamp output one.
// R17: Jig sensors count only with jig function and sensor enabled.
// R18: Barcode read input allows barcode load only with comm disabled.
// R19: Thickness clear turns off thickness OK and both NG outputs.
// R20: Stitch fault clear turns off stitch OK and NG outputs.
// R21: Second stitch fault clear turns off second OK and NG outputs.
// R22: Step inputs act once per inactive-to-active transition.
// R23: Speed dial saturates at 9 upward and 0 downward.
`include "mifd_cfg.svh"

module machine_input_function_decoder (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Counter inputs
  input wire logic down_count_clear_in_i,
  input wire logic up_count_inc_in_i,
  input wire logic up_count_dec_in_i,
  input wire logic down_count_inc_in_i,
  input wire logic down_count_dec_in_i,
  output mifd_pkg::count_t up_count_o,
  output mifd_pkg::count_t down_count_o,
  // Panel keys and icons with their lockout inputs
  input wire logic [9:0] panel_key_i,
  input wire logic [9:0] key_lock_i,
  output logic [9:0] panel_key_o,
  input wire logic [3:0] panel_icon_i,
  input wire logic [3:0] icon_lock_i,
  output logic [3:0] panel_icon_o,
  // Pattern select
  input wire logic [5:0] pattern_weight_i,
  output mifd_pkg::pattern_num_t pattern_number_o,
  output logic pattern_select_valid_o,
  // Head tilt
  input wire logic head_tilt_in_i,
  output logic head_tilt_msg_o,
  // Speed dial
  input wire logic [9:0] speed_select_in_i,
  input wire logic speed_step_up_in_i,
  input wire logic speed_step_down_in_i,
  output mifd_pkg::speed_t speed_dial_o,
  // Cassette jig
  input wire logic jig_sensor_a_i,
  input wire logic jig_sensor_b_i,
  output logic clamp_out_first_o,
  // Barcode
  input wire logic barcode_read_in_i,
  output logic barcode_load_req_o,
  // Detection results
  input wire logic [6:0] result_set_i,
  input wire logic thickness_result_clear_in_i,
  input wire logic stitch_fault_clear_in_i,
  input wire logic stitch_fault_b_clear_in_i,
  output logic thickness_ok_out_o,
  output logic thickness_ng_pos_out_o,
  output logic thickness_ng_neg_out_o,
  output logic stitch_ok_out_o,
  output logic stitch_ng_out_o,
  output logic stitch_b_ok_out_o,
  output logic stitch_b_ng_out_o
);
  import mifd_pkg::*;

  // ----------------------------------------------------------------------
  // State and event wiring
  // ----------------------------------------------------------------------
  state_t state_r;
  state_t state_nxt;
  event_vec_t evt_now;
  event_vec_t evt_edge;
  pattern_num_t base;
  pattern_num_t weights;
  logic jig_enabled;
  result_t result_clr;

  // Gather step inputs into one vector so one history register serves all
  assign evt_now = {speed_select_in_i,
                    stitch_fault_b_clear_in_i,
                    stitch_fault_clear_in_i,
                    thickness_result_clear_in_i,
                    barcode_read_in_i,
                    speed_step_down_in_i,
                    speed_step_up_in_i,
                    down_count_dec_in_i,
                    down_count_inc_in_i,
                    up_count_dec_in_i,
                    up_count_inc_in_i};

  // Rising edges only, so a held switch steps just once
  assign evt_edge = evt_now & ~state_r.evt_prev; // [R22]

  // Pattern base from the offset field
  always_comb begin
    unique case (state_r.cfg[`CFG_BASE_HI:`CFG_BASE_LO])
      2'h0: base = `PATTERN_BASE_0; // [R11]
      2'h1: base = `PATTERN_BASE_1;
      2'h2: base = `PATTERN_BASE_2;
      2'h3: base = `PATTERN_BASE_3;
    endcase
  end

  // Six weights add up to at most 63, so base 1000 tops out at 1063
  assign weights = {7'h00, pattern_weight_i}; // [R8] [R9]

  // Jig sensors count only with both settings on
  assign jig_enabled = state_r.cfg[`CFG_JIG_FUNC_EN]
                     & state_r.cfg[`CFG_JIG_SENSOR_EN]; // [R17]

  // Result bits dropped by each clear event
  always_comb begin
    result_clr = 7'h00;
    if (evt_edge[`EV_THICK_CLR]) begin
      result_clr[`RES_THICK_OK] = 1'b1; // [R19]
      result_clr[`RES_THICK_NG_POS] = 1'b1;
      result_clr[`RES_THICK_NG_NEG] = 1'b1;
    end
    if (evt_edge[`EV_STITCH_CLR]) begin
      result_clr[`RES_STITCH_OK] = 1'b1; // [R20]
      result_clr[`RES_STITCH_NG] = 1'b1;
    end
    if (evt_edge[`EV_STITCH_B_CLR]) begin
      result_clr[`RES_STITCH_B_OK] = 1'b1; // [R21]
      result_clr[`RES_STITCH_B_NG] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.evt_prev = evt_now;
    state_nxt.rdata = 32'h0000_0000;

    // Software writes come first so that input events override them
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `REG_CONFIG: state_nxt.cfg = reg_wdata_i[5:0];
        `REG_UP_COUNT: state_nxt.up_count = reg_wdata_i[15:0];
        `REG_DOWN_COUNT: state_nxt.down_count = reg_wdata_i[15:0];
        `REG_SPEED: begin
          // Out of range writes clamp rather than wrap
          if (reg_wdata_i[31:4] != 28'h0 ||
              reg_wdata_i[3:0] > `SPEED_MAX) begin
            state_nxt.speed = `SPEED_MAX;
          end else begin
            state_nxt.speed = reg_wdata_i[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Up counter: opposite steps in one cycle cancel
    if (evt_edge[`EV_UP_INC] && !evt_edge[`EV_UP_DEC]) begin
      state_nxt.up_count = state_r.up_count + 16'h0001; // [R2]
    end else if (evt_edge[`EV_UP_DEC] && !evt_edge[`EV_UP_INC]) begin
      state_nxt.up_count = state_r.up_count - 16'h0001; // [R3]
    end

    // Down counter: steps, then the level clear dominates
    if (evt_edge[`EV_DN_INC] && !evt_edge[`EV_DN_DEC]) begin
      state_nxt.down_count = state_r.down_count + 16'h0001; // [R4]
    end else if (evt_edge[`EV_DN_DEC] && !evt_edge[`EV_DN_INC]) begin
      state_nxt.down_count = state_r.down_count - 16'h0001; // [R5]
    end
    if (down_count_clear_in_i) begin
      state_nxt.down_count = `COUNT_RESET; // [R1]
    end

    // Speed steps saturate at both ends
    if (evt_edge[`EV_SPD_UP] && !evt_edge[`EV_SPD_DN]) begin
      if (state_r.speed < `SPEED_MAX) begin
        state_nxt.speed = state_r.speed + 4'h1; // [R14] [R23]
      end else begin
        state_nxt.speed = `SPEED_MAX;
      end
    end else if (evt_edge[`EV_SPD_DN] && !evt_edge[`EV_SPD_UP]) begin
      if (state_r.speed > `SPEED_MIN) begin
        state_nxt.speed = state_r.speed - 4'h1; // [R15] [R23]
      end else begin
        state_nxt.speed = `SPEED_MIN;
      end
    end

    // Direct select beats stepping; lowest index wins a tie
    for (int i = 9; i >= 0; i--) begin
      if (evt_edge[`EV_SEL_LO + i]) begin
        state_nxt.speed = 4'(i); // [R13]
      end
    end

    // Pattern number follows the weights only while enabled
    if (state_r.cfg[`CFG_EXT_PATTERN_EN]) begin
      state_nxt.pattern_num = base + weights; // [R8] [R10] [R11]
      state_nxt.pattern_valid = 1'b1;
    end else begin
      state_nxt.pattern_valid = 1'b0; // [R10]
    end

    // Message held as long as the head stays tilted
    state_nxt.head_tilt_msg = head_tilt_in_i; // [R12]

    // Locked keys and icons never reach the panel logic
    state_nxt.key_out = panel_key_i & ~key_lock_i; // [R6]
    state_nxt.icon_out = panel_icon_i & ~icon_lock_i; // [R7]

    // Clamp follows both sensors while the jig is enabled
    state_nxt.clamp = jig_enabled & jig_sensor_a_i
                    & jig_sensor_b_i; // [R16] [R17]

    // One-cycle barcode load request, blocked while comm is on
    state_nxt.barcode_req = evt_edge[`EV_BARCODE]
                          & ~state_r.cfg[`CFG_COMM_SETTING]; // [R18]

    // A new result in the clearing cycle survives the clear
    state_nxt.results = (state_r.results & ~result_clr)
                      | result_set_i; // [R19] [R20] [R21]

    // Register read data, valid in the cycle after the strobe only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `REG_CONFIG: state_nxt.rdata = {26'h0, state_r.cfg};
        `REG_UP_COUNT: state_nxt.rdata = {16'h0, state_r.up_count};
        `REG_DOWN_COUNT: state_nxt.rdata = {16'h0, state_r.down_count};
        `REG_PATTERN: state_nxt.rdata = {19'h0, state_r.pattern_num};
        `REG_SPEED: state_nxt.rdata = {28'h0, state_r.speed};
        `REG_STATUS: begin
          state_nxt.rdata = {21'h0,
                             state_r.results,
                             state_r.pattern_valid,
                             ~state_r.cfg[`CFG_COMM_SETTING],
                             state_r.clamp,
                             state_r.head_tilt_msg};
        end
        default: state_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset history to zero: a switch held through reset steps once on exit
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r.evt_prev <= 20'h0_0000;
      state_r.cfg <= `CFG_RESET;
      state_r.up_count <= `COUNT_RESET;
      state_r.down_count <= `COUNT_RESET;
      state_r.speed <= `SPEED_RESET;
      state_r.pattern_num <= `PATTERN_BASE_0;
      state_r.pattern_valid <= 1'b0;
      state_r.head_tilt_msg <= 1'b0;
      state_r.key_out <= 10'h000;
      state_r.icon_out <= 4'h0;
      state_r.clamp <= 1'b0;
      state_r.barcode_req <= 1'b0;
      state_r.results <= 7'h00;
      state_r.rdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------------
  assign reg_rdata_o = state_r.rdata;
  assign up_count_o = state_r.up_count;
  assign down_count_o = state_r.down_count;
  assign panel_key_o = state_r.key_out;
  assign panel_icon_o = state_r.icon_out;
  assign pattern_number_o = state_r.pattern_num;
  assign pattern_select_valid_o = state_r.pattern_valid;
  assign head_tilt_msg_o = state_r.head_tilt_msg;
  assign speed_dial_o = state_r.speed;
  assign clamp_out_first_o = state_r.clamp;
  assign barcode_load_req_o = state_r.barcode_req;
  assign thickness_ok_out_o = state_r.results[`RES_THICK_OK];
  assign thickness_ng_pos_out_o = state_r.results[`RES_THICK_NG_POS];
  assign thickness_ng_neg_out_o = state_r.results[`RES_THICK_NG_NEG];
  assign stitch_ok_out_o = state_r.results[`RES_STITCH_OK];
  assign stitch_ng_out_o = state_r.results[`RES_STITCH_NG];
  assign stitch_b_ok_out_o = state_r.results[`RES_STITCH_B_OK];
  assign stitch_b_ng_out_o = state_r.results[`RES_STITCH_B_NG];

endmodule // machine_input_function_decoder

/* verification/switch_bank_model.sv */
// Model of the machine-side push buttons and clear switches.
// Assumes the bench requests presses as levels at rising edges.
module switch_bank_model (
  input wire logic core_clk_i,
  input wire logic slow_i,
  input wire logic [9:0] press_i,
  output logic [9:0] contact_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] stage_r;
  // ---------
  // Contacts
  // ---------
  // Released contacts rest low on their pull-down
  initial begin
    stage_r = 10'h000;
    contact_o = 10'h000;
  end
  // Slow mode adds a cycle, as long field wiring would
  always @(posedge core_clk_i) begin
    stage_r <= press_i;
    contact_o <= slow_i ? stage_r : press_i;
  end
endmodule // switch_bank_model

/* verification/mifd_sva.sv */
// Assertions on the decoder's top-level ports.
// Assumes one clock and a synchronous active-high reset.
module mifd_checker (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic down_count_clear_in_i,
  input wire logic up_count_inc_in_i,
  input wire logic up_count_dec_in_i,
  input wire mifd_pkg::count_t up_count_o,
  input wire mifd_pkg::count_t down_count_o,
  input wire logic [9:0] panel_key_i,
  input wire logic [9:0] key_lock_i,
  input wire logic [9:0] panel_key_o,
  input wire logic [5:0] pattern_weight_i,
  input wire mifd_pkg::pattern_num_t pattern_number_o,
  input wire logic pattern_select_valid_o,
  input wire logic head_tilt_in_i,
  input wire logic head_tilt_msg_o,
  input wire logic [9:0] speed_select_in_i,
  input wire logic speed_step_up_in_i,
  input wire logic speed_step_down_in_i,
  input wire mifd_pkg::speed_t speed_dial_o,
  input wire logic jig_sensor_a_i,
  input wire logic jig_sensor_b_i,
  input wire logic clamp_out_first_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mifd_pkg::*;
  logic quiet;
  // Steps are judged only when no select edge or write competes
  assign quiet = speed_select_in_i == 10'h000 && !reg_wr_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ---------
  // Rules
  // ---------
  property p_dn_clear;
    down_count_clear_in_i |=> down_count_o == 16'h0000;
  endproperty
  a_dn_clear: assert property (p_dn_clear)
    else $error("down count not held at zero");
  property p_up_inc;
    $rose(up_count_inc_in_i) && !$rose(up_count_dec_in_i) && !reg_wr_i
      |=> up_count_o == $past(up_count_o) + 16'h0001;
  endproperty
  a_up_inc: assert property (p_up_inc)
    else $error("up count missed a step");
  property p_keys;
    1 |=> panel_key_o == ($past(panel_key_i) & ~$past(key_lock_i));
  endproperty
  a_keys: assert property (p_keys)
    else $error("locked key passed");
  property p_pattern;
    pattern_select_valid_o ##1 pattern_select_valid_o
      |-> pattern_number_o % 13'h3E8 == 13'($past(pattern_weight_i));
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("pattern number wrong");
  property p_tilt;
    1 |=> head_tilt_msg_o == $past(head_tilt_in_i);
  endproperty
  a_tilt: assert property (p_tilt)
    else $error("tilt message wrong");
  property p_spd_up;
    $rose(speed_step_up_in_i) && !$rose(speed_step_down_in_i) && quiet
      |=> speed_dial_o == (($past(speed_dial_o) == 4'h9) ? 4'h9
        : $past(speed_dial_o) + 4'h1);
  endproperty
  a_spd_up: assert property (p_spd_up)
    else $error("speed up step wrong");
  property p_spd_dn;
    $rose(speed_step_down_in_i) && !$rose(speed_step_up_in_i) && quiet
      |=> speed_dial_o == (($past(speed_dial_o) == 4'h0) ? 4'h0
        : $past(speed_dial_o) - 4'h1);
  endproperty
  a_spd_dn: assert property (p_spd_dn)
    else $error("speed down step wrong");
  property p_clamp;
    clamp_out_first_o |-> $past(jig_sensor_a_i) && $past(jig_sensor_b_i);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp without both sensors");
  c_up: cover property ($rose(up_count_inc_in_i));
  c_clamp: cover property (clamp_out_first_o);
  c_top: cover property (speed_dial_o == 4'h9);
endmodule // mifd_checker

bind machine_input_function_decoder mifd_checker i_mifd_checker (.*);

/* verification/machine_input_function_decoder_test.sv */
// Self-checking bench for the machine input function decoder.
// Assumes the design, the switch model and the checker are compiled.
`include "mifd_cfg.svh"
module machine_input_function_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mifd_pkg::*;
  logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, slow;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, seed;
  logic down_count_clear_in_i, head_tilt_in_i;
  logic jig_sensor_a_i, jig_sensor_b_i;
  wire up_count_inc_in_i, up_count_dec_in_i, down_count_inc_in_i;
  wire down_count_dec_in_i, speed_step_up_in_i, speed_step_down_in_i;
  wire barcode_read_in_i, thickness_result_clear_in_i;
  wire stitch_fault_clear_in_i, stitch_fault_b_clear_in_i;
  logic [9:0] press, contact, panel_key_i, key_lock_i, panel_key_o;
  logic [9:0] speed_select_in_i;
  logic [3:0] panel_icon_i, icon_lock_i, panel_icon_o;
  logic [5:0] pattern_weight_i;
  logic [6:0] result_set_i, res;
  count_t up_count_o, down_count_o;
  pattern_num_t pattern_number_o;
  speed_t speed_dial_o;
  logic pattern_select_valid_o, head_tilt_msg_o, clamp_out_first_o;
  logic barcode_load_req_o, thickness_ok_out_o, thickness_ng_pos_out_o;
  logic thickness_ng_neg_out_o, stitch_ok_out_o, stitch_ng_out_o;
  logic stitch_b_ok_out_o, stitch_b_ng_out_o;
  int miscompares, total_checks, bc_cnt, spd_m, res_m, pat_m;
  int cnt_m[2];
  int clr_mask[3] = '{32'h07, 32'h18, 32'h60};
  assign {stitch_fault_b_clear_in_i, stitch_fault_clear_in_i,
    thickness_result_clear_in_i, barcode_read_in_i, speed_step_down_in_i,
    speed_step_up_in_i, down_count_dec_in_i, down_count_inc_in_i,
    up_count_dec_in_i, up_count_inc_in_i} = contact;
  assign res = {stitch_b_ng_out_o, stitch_b_ok_out_o, stitch_ng_out_o,
    stitch_ok_out_o, thickness_ng_neg_out_o, thickness_ng_pos_out_o,
    thickness_ok_out_o};
  switch_bank_model i_switch_bank_model (.core_clk_i(core_clk_i),
    .slow_i(slow), .press_i(press), .contact_o(contact));
  machine_input_function_decoder i_machine_input_function_decoder (.*);
  // ---------
  // Helpers
  // ---------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Arguments are copied at the call: callers sample at the edge, reg_read and the key loop 1 ns after it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    #1;
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask
  // Switch held for len cycles, then released long enough to settle
  task automatic press_key(input int b, input int len);
    @(posedge core_clk_i);
    press <= 10'h001 << b;
    repeat (len) @(posedge core_clk_i);
    press <= 10'h000;
    repeat (4) @(posedge core_clk_i);
  endtask
  // ---------
  // Clock, monitor, watchdog
  // ---------
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // The request lasts one cycle, so it is counted rather than sampled
  always @(posedge core_clk_i) begin
    if (barcode_load_req_o === 1'b1) begin
      bc_cnt <= bc_cnt + 1;
    end
  end
  initial begin
    #60000;
    miscompares++;
    give_verdict();
  end
  // ---------
  // Scenarios
  // ---------
  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, press, slow} = '0;
    {panel_key_i, key_lock_i, panel_icon_i, icon_lock_i} = '0;
    {pattern_weight_i, speed_select_in_i, result_set_i} = '0;
    {down_count_clear_in_i, head_tilt_in_i} = '0;
    {jig_sensor_a_i, jig_sensor_b_i} = '0;
    sys_rst_i = 1'b1;
    seed = 32'h159BA;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    check(pattern_number_o, 32'h3E8);
    check({up_count_o, down_count_o}, 32'h0);
    // Counter steps from the top of the range, held and slow contacts
    reg_write(`REG_UP_COUNT, 32'h0000FFFF);
    press_key(0, 1);
    check(up_count_o, 32'h0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      slow = seed[4];
      press_key(seed[1:0], 1 + seed[3:2]);
      cnt_m[seed[1]] = (cnt_m[seed[1]] + (seed[0] ? -1 : 1)) & 32'hFFFF;
      check(up_count_o, cnt_m[0]);
      check(down_count_o, cnt_m[1]);
    end
    // A held clear beats a down step arriving meanwhile
    @(posedge core_clk_i);
    down_count_clear_in_i <= 1'b1;
    press_key(2, 1);
    check(down_count_o, 32'h0);
    @(posedge core_clk_i);
    down_count_clear_in_i <= 1'b0;
    reg_read(`REG_DOWN_COUNT, 32'h0);
    // Random key and icon presses under random lockouts
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge core_clk_i);
      {panel_key_i, key_lock_i, panel_icon_i, icon_lock_i} <= seed[27:0];
      @(posedge core_clk_i);
      #1;
      check(panel_key_o, panel_key_i & ~key_lock_i);
      check(panel_icon_o, panel_icon_i & ~icon_lock_i);
    end
    // Every base, all weights set on the default base
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      reg_write(`REG_CONFIG, 32'((b << 1) | 1));
      pattern_weight_i <= (b == 0) ? 6'h3F : seed[5:0];
      repeat (2) @(posedge core_clk_i);
      pat_m = 32'h3E8 * (b + 1) + pattern_weight_i;
      check(pattern_number_o, pat_m);
      check(pattern_select_valid_o, 1'b1);
    end
    // With selection off the weights are ignored
    reg_write(`REG_CONFIG, 32'h0);
    pattern_weight_i <= 6'h15;
    repeat (2) @(posedge core_clk_i);
    check(pattern_number_o, pat_m);
    check(pattern_select_valid_o, 1'b0);
    reg_read(`REG_PATTERN, pat_m);
    // Select every dial value, then step past both ends
    for (int i = 9; i >= 0; i--) begin
      @(posedge core_clk_i);
      speed_select_in_i <= 10'h001 << i;
      @(posedge core_clk_i);
      speed_select_in_i <= 10'h000;
      @(posedge core_clk_i);
      check(speed_dial_o, i);
    end
    for (int i = 0; i < 22; i++) begin
      press_key((i < 11) ? 4 : 5, 1);
      spd_m = (i < 11) ? ((spd_m == 9) ? 9 : spd_m + 1)
        : ((spd_m == 0) ? 0 : spd_m - 1);
      check(speed_dial_o, spd_m);
    end
    reg_write(`REG_SPEED, 32'hF);
    reg_read(`REG_SPEED, 32'h9);
    for (int i = 1; i >= 0; i--) begin
      @(posedge core_clk_i);
      head_tilt_in_i <= 1'(i);
      repeat (2) @(posedge core_clk_i);
      check(head_tilt_msg_o, i);
    end
    // Clamp needs both sensors and both jig enables
    for (int j = 0; j < 5; j++) begin
      reg_write(`REG_CONFIG, 32'(((j > 3) ? 3 : j) << 3));
      jig_sensor_a_i <= 1'b1;
      jig_sensor_b_i <= (j != 4);
      repeat (2) @(posedge core_clk_i);
      check(clamp_out_first_o, j == 3);
    end
    // Barcode request honoured only with the comm setting off
    for (int j = 0; j < 2; j++) begin
      reg_write(`REG_CONFIG, 32'(j << 5));
      press_key(6, 2);
      check(bc_cnt, 1);
    end
    // Set every result, then clear one group at a time
    @(posedge core_clk_i);
    result_set_i <= 7'h7F;
    @(posedge core_clk_i);
    result_set_i <= 7'h00;
    res_m = 32'h7F;
    for (int c = 0; c < 3; c++) begin
      press_key(7 + c, 1);
      res_m = res_m & ~clr_mask[c];
      check(res, res_m);
    end
    reg_read(8'hFC, 32'h0);
    reg_read(`REG_UP_COUNT, cnt_m[0]);
    give_verdict();
  end
endmodule // machine_input_function_decoder_test
